// file: hw/e1rfp_consts.svh
// offsets, field positions, reset values and timing figures of the e1 receive framer
`ifndef E1RFP_CONSTS_SVH
`define E1RFP_CONSTS_SVH
`define E1RFP_GLOB_OFS 8'h00
`define E1RFP_MODE_OFS 8'h04
`define E1RFP_CTRL_OFS 8'h08
`define E1RFP_STAT_OFS 8'h0c
`define E1RFP_EVT_OFS 8'h10
`define E1RFP_IEN_OFS 8'h14
`define E1RFP_OVH_OFS 8'h18
`define E1RFP_SACODE_OFS 8'h1c
`define E1RFP_CRCCNT_OFS 8'h20
`define E1RFP_GLOB_RST 1'h1
`define E1RFP_MODE_RST 4'h0
`define E1RFP_CTRL_RST 11'h000
`define E1RFP_IEN_RST 6'h00
`define E1RFP_STAT_RST 8'h05
`define E1RFP_EV_FER 0
`define E1RFP_EV_CMFER 1
`define E1RFP_EV_SMFER 2
`define E1RFP_EV_CRC 3
`define E1RFP_EV_PER 4
`define E1RFP_EV_CHG 5
`define E1RFP_EV_W 6
`define E1RFP_FAS 7'h1b
`define E1RFP_CMF_PAT 6'h0b
`define E1RFP_CRC_LIMIT 10'h392
`define E1RFP_FRAME_NS 125000
`define E1RFP_AIS_MS 100
`define E1RFP_RED_MS 100
`define E1RFP_CMF_MS 400
`define E1RFP_WIN_MS 8
`define E1RFP_SEC_MS 1000
`endif

// file: hw/e1rfp_pkg.sv
// types shared by the e1 receive framer
package e1rfp_pkg;
	typedef enum logic [2:0] {
		FS_HUNT = 3'h0,
		FS_NFAS = 3'h1,
		FS_FAS2 = 3'h2,
		FS_SYNC = 3'h3,
		FS_BYP = 3'h4
	} e1rfp_fstate_t;
	typedef struct packed {
		logic e1;
		logic rx_j1;
		logic tx_j1;
	} e1rfp_mode_t;
	typedef struct packed {
		logic loss3;
		logic [1:0] per_sel;
		logic deb3;
		logic oof_crit;
		logic unframed;
		logic cas_dis;
		logic crc_en;
		logic reframe;
		logic ref_crce;
		logic refr_dis;
	} e1rfp_ctrl_t;
	typedef struct packed {
		logic excrc;
		logic red;
		logic ais;
		logic rmai;
		logic rai;
		logic oosmf;
		logic oocmf;
		logic oof;
	} e1rfp_stat_t;
	typedef struct packed {
		e1rfp_fstate_t st;
		logic [7:0] pos;
		logic [7:0] sr;
		logic fas;
		logic [1:0] errc;
		logic [1:0] zeros;
		logic [3:0] mf;
		logic [1:0] cmf;
		logic [1:0] cmf_errc;
		logic [6:0] t8;
		logic [11:0] t400;
		logic [5:0] si_sh;
		logic [3:0] crc;
		logic [3:0] rem;
		logic [3:0] crx;
		logic crun;
		logic rem_ok;
		logic [9:0] crc_cnt;
		logic [9:0] crc_rep;
		logic [12:0] sec;
		logic excrc;
		logic [3:0] sm;
		logic cas;
		logic [1:0] cas_errc;
		logic [3:0] rai_d;
		logic [3:0] rmai_d;
		logic [9:0] ais_cnt;
		logic [9:0] red_cnt;
		logic ais;
		logic red;
		logic si_fas;
		logic si_nfas;
		logic [4:0] nat;
		logic [2:0] xb;
		logic [19:0] sa_sh;
		logic [19:0] sa_code;
		logic ts16;
		logic ts16_en;
	} e1rfp_frm_t;
endpackage

// file: hw/e1rfp_frame_processor.sv
// e1 receive frame processor of one framer port with wishbone registers
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "e1rfp_consts.svh"
module e1rfp_frame_processor #(
	parameter int AIS_FRAMES = `E1RFP_AIS_MS * 1000000 / `E1RFP_FRAME_NS,
	parameter int RED_FRAMES = `E1RFP_RED_MS * 1000000 / `E1RFP_FRAME_NS,
	parameter int CMF_FRAMES = `E1RFP_CMF_MS * 1000000 / `E1RFP_FRAME_NS,
	parameter int WIN_FRAMES = `E1RFP_WIN_MS * 1000000 / `E1RFP_FRAME_NS,
	parameter int SEC_FRAMES = `E1RFP_SEC_MS * 1000000 / `E1RFP_FRAME_NS
) (
	input logic clk_i,
	input logic rst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input logic rx_bit_i,
	input logic rx_bit_en_i,
	output logic ts16_o,
	output logic ts16_en_o,
	output logic int_o,
	output e1rfp_pkg::e1rfp_mode_t mode_o
);
	import e1rfp_pkg::*;

	localparam logic [5:0] CMF_PAT = `E1RFP_CMF_PAT;

	e1rfp_frm_t fr_r, fr_nxt;
	logic glob_r, glob_nxt;
	logic [3:0] mode_r, mode_nxt;
	e1rfp_ctrl_t ctrl_r, ctrl_nxt;
	logic [5:0] ev_r, ev_nxt, inten_r, inten_nxt, ev_set, clr;
	e1rfp_stat_t stat, stat_prev_r;
	logic ack_r, ack_nxt, int_r, int_nxt, refp_r;
	logic [31:0] dat_r, dat_nxt, rd, wv, m;
	e1rfp_mode_t mode_q_r, mode_q_nxt;
	logic acc, restart, e1_on, bit_v, fend, smf_end, sync, err, db, fb, cas_ok;
	logic [7:0] p, sh, a;
	logic [1:0] z;

	// state {last value, run length, debounced output}
	function automatic logic [3:0] deb(input logic v, input logic [3:0] s, input logic three);
		logic [1:0] run;
		logic o;
		run = (v != s[3]) ? 2'h1 : ((s[2:1] == 2'h3) ? 2'h3 : s[2:1] + 2'h1);
		o = (run >= (three ? 2'h3 : 2'h2)) ? v : s[0];
		return {v, run, o};
	endfunction

	assign e1_on = !glob_r;
	assign restart = ctrl_r.reframe && !refp_r;

	always_comb begin
		fr_nxt = fr_r;
		fr_nxt.ts16_en = 1'b0;
		ev_set = '0;
		bit_v = rx_bit_i;
		p = fr_r.pos;
		sh = {fr_r.sr[6:0], bit_v};
		sync = (fr_r.st == FS_SYNC);
		fend = (p == 8'hff);
		smf_end = fend && sync && (fr_r.mf[2:0] == 3'h7);
		err = 1'b0;
		db = 1'b0;
		fb = 1'b0;
		z = fr_r.zeros;
		if (!e1_on || restart) begin
			fr_nxt.st = FS_HUNT;
		end else if (ctrl_r.unframed) begin
			fr_nxt.st = FS_BYP;
		end else if (fr_r.st == FS_BYP) begin
			fr_nxt.st = FS_HUNT;
		end else if (rx_bit_en_i) begin
			// one bit per enable, 256 bits a frame
			fr_nxt.sr = sh;
			fr_nxt.pos = p + 8'h01;
			if (!bit_v && z != 2'h3) begin
				z = z + 2'h1;
			end
			fr_nxt.zeros = z;
			unique case (fr_r.st)
				FS_HUNT: begin
					if (sh[6:0] == `E1RFP_FAS) begin
						fr_nxt.pos = 8'h08;
						fr_nxt.st = FS_NFAS;
					end
				end
				FS_NFAS: begin
					if (p == 8'h07) begin
						fr_nxt.st = sh[6] ? FS_FAS2 : FS_HUNT;
					end
				end
				FS_FAS2: begin
					if (p == 8'h07) begin
						fr_nxt.st = (sh[6:0] == `E1RFP_FAS) ? FS_SYNC : FS_HUNT;
						fr_nxt.fas = 1'b1;
					end
				end
				FS_SYNC: begin
					if (p == 8'h07) begin
						if (fr_r.fas) begin
							err = (sh[6:0] != `E1RFP_FAS);
							fr_nxt.si_fas = sh[7];
							fr_nxt.crx = {fr_r.crx[2:0], sh[7]};
						end else begin
							err = !sh[6] && ctrl_r.oof_crit;
							fr_nxt.si_nfas = sh[7];
							fr_nxt.nat = sh[4:0];
							fr_nxt.si_sh = {fr_r.si_sh[4:0], sh[7]};
							fr_nxt.rai_d = deb(sh[5], fr_r.rai_d, ctrl_r.deb3);
							for (int k = 0; k < 5; k++) begin
								fr_nxt.sa_sh[k*4 +: 4] = {fr_r.sa_sh[k*4 +: 3], sh[4-k]};
							end
							if (ctrl_r.crc_en && fr_r.cmf != 2'h2) begin
								// two hits 16 frames apart
								if ({fr_r.si_sh[4:0], sh[7]} == CMF_PAT) begin
									fr_nxt.mf = 4'hb;
									fr_nxt.t8 = '0;
									fr_nxt.cmf = (fr_r.cmf == 2'h1 && fr_r.mf == 4'hb) ? 2'h2 : 2'h1;
								end
							end else if (fr_r.cmf == 2'h2 && fr_r.mf < 4'hc) begin
								if (sh[7] != CMF_PAT[3'h5 - fr_r.mf[3:1]]) begin
									ev_set[`E1RFP_EV_CMFER] = 1'b1;
									fr_nxt.cmf_errc = fr_r.cmf_errc + 2'h1;
									if (fr_r.cmf_errc == (ctrl_r.loss3 ? 2'h2 : 2'h1)) begin
										fr_nxt.cmf = 2'h0;
									end
								end else begin
									fr_nxt.cmf_errc = 2'h0;
								end
							end
						end
						ev_set[`E1RFP_EV_FER] = err;
						if (fr_r.fas || ctrl_r.oof_crit) begin
							fr_nxt.errc = err ? fr_r.errc + 2'h1 : 2'h0;
							// three bad words in a row
							if (err && fr_r.errc == 2'h2 && !ctrl_r.refr_dis) begin
								fr_nxt.st = FS_HUNT;
							end
						end
					end
					// C bit slots enter the check as zero
					db = bit_v && !(p == 8'h00 && fr_r.fas);
					fb = db ^ fr_r.crc[3];
					fr_nxt.crc = {fr_r.crc[2:0], 1'b0} ^ {2'h0, fb, fb};
					if (p[7:3] == 5'h10) begin
						fr_nxt.ts16 = bit_v;
						fr_nxt.ts16_en = 1'b1;
					end
					if (p == 8'h87 && fr_nxt.st == FS_SYNC && !ctrl_r.cas_dis &&
							(!ctrl_r.crc_en || fr_r.cmf == 2'h2)) begin
						if (!fr_r.cas) begin
							if (sh[7:4] == 4'h0) begin
								fr_nxt.cas = 1'b1;
								fr_nxt.sm = 4'h0;
							end
						end else if (fr_r.sm == 4'h0) begin
							fr_nxt.xb = {sh[3], sh[1], sh[0]};
							fr_nxt.rmai_d = deb(sh[2], fr_r.rmai_d, ctrl_r.deb3);
							if (sh[7:4] != 4'h0) begin
								ev_set[`E1RFP_EV_SMFER] = 1'b1;
								fr_nxt.cas_errc = fr_r.cas_errc + 2'h1;
								if (fr_r.cas_errc == (ctrl_r.loss3 ? 2'h2 : 2'h1)) begin
									fr_nxt.cas = 1'b0;
								end
							end else begin
								fr_nxt.cas_errc = 2'h0;
							end
						end
					end
					if (smf_end) begin
						if (fr_r.rem_ok && fr_r.crx != fr_r.rem) begin
							ev_set[`E1RFP_EV_CRC] = 1'b1;
							if (fr_r.crc_cnt != 10'h3ff) begin
								fr_nxt.crc_cnt = fr_r.crc_cnt + 10'h001;
							end
						end
						fr_nxt.rem = fr_nxt.crc;
						fr_nxt.crc = 4'h0;
						fr_nxt.rem_ok = fr_r.crun;
						fr_nxt.crun = (fr_r.cmf == 2'h2);
						fr_nxt.sa_code = fr_r.sa_sh;
					end
					if (fend) begin
						fr_nxt.fas = !fr_r.fas;
						fr_nxt.mf = fr_r.mf + 4'h1;
						fr_nxt.sm = fr_r.sm + 4'h1;
						if (fr_r.cmf == 2'h1) begin
							fr_nxt.t8 = fr_r.t8 + 7'h01;
							if (fr_r.t8 == 7'(WIN_FRAMES - 1)) begin
								fr_nxt.cmf = 2'h0;
							end
						end
						fr_nxt.t400 = fr_r.t400 + 12'h001;
						if (fr_r.t400 == 12'(CMF_FRAMES - 1)) begin
							fr_nxt.st = FS_HUNT;
						end
						fr_nxt.sec = fr_r.sec + 13'h0001;
						if (fr_r.sec == 13'(SEC_FRAMES - 1)) begin
							fr_nxt.sec = '0;
							fr_nxt.crc_rep = fr_nxt.crc_cnt;
							fr_nxt.crc_cnt = '0;
							// judge the count just banked, the live one is already cleared
							fr_nxt.excrc = (fr_nxt.crc_rep > `E1RFP_CRC_LIMIT);
							if (fr_nxt.crc_rep > `E1RFP_CRC_LIMIT && ctrl_r.ref_crce &&
									!ctrl_r.refr_dis) begin
								fr_nxt.st = FS_HUNT;
							end
						end
						unique case (ctrl_r.per_sel)
							2'h0: ev_set[`E1RFP_EV_PER] = 1'b1;
							2'h1: ev_set[`E1RFP_EV_PER] = (fr_r.mf[2:0] == 3'h7) && fr_r.cmf == 2'h2;
							2'h2: ev_set[`E1RFP_EV_PER] = (fr_r.mf == 4'hf) && fr_r.cmf == 2'h2;
							2'h3: ev_set[`E1RFP_EV_PER] = (fr_r.sm == 4'hf) && fr_r.cas;
						endcase
					end
				end
				default: fr_nxt.st = FS_HUNT;
			endcase
			if (fend) begin
				// timed in received frames, not in clock cycles
				fr_nxt.zeros = 2'h0;
				if (z != 2'h3) begin
					if (fr_r.ais_cnt != 10'(AIS_FRAMES)) begin
						fr_nxt.ais_cnt = fr_r.ais_cnt + 10'h001;
					end
				end else begin
					fr_nxt.ais_cnt = '0;
				end
				fr_nxt.ais = (fr_nxt.ais_cnt == 10'(AIS_FRAMES));
				if (!sync) begin
					if (fr_r.red_cnt != 10'(RED_FRAMES)) begin
						fr_nxt.red_cnt = fr_r.red_cnt + 10'h001;
					end
				end else begin
					fr_nxt.red_cnt = '0;
				end
				fr_nxt.red = (fr_nxt.red_cnt == 10'(RED_FRAMES));
			end
		end
		// dependent searches fall back whenever their parent is lost
		if (fr_nxt.st != FS_SYNC || !ctrl_r.crc_en) begin
			fr_nxt.cmf = 2'h0;
			fr_nxt.crun = 1'b0;
			fr_nxt.rem_ok = 1'b0;
		end
		if (fr_nxt.st != FS_SYNC) begin
			fr_nxt.errc = 2'h0;
		end
		if (fr_nxt.cmf != 2'h2) begin
			fr_nxt.cmf_errc = 2'h0;
		end
		if (fr_nxt.cmf == 2'h0) begin
			fr_nxt.t8 = '0;
		end
		if (fr_nxt.cmf == 2'h2 || !ctrl_r.crc_en || fr_nxt.st != FS_SYNC) begin
			fr_nxt.t400 = '0;
		end
		cas_ok = fr_nxt.st == FS_SYNC && !ctrl_r.cas_dis && (!ctrl_r.crc_en || fr_nxt.cmf == 2'h2);
		if (!cas_ok) begin
			fr_nxt.cas = 1'b0;
			fr_nxt.cas_errc = 2'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fr_r <= '0;
		end else begin
			fr_r <= fr_nxt;
		end
	end

	always_comb begin
		stat.oof = (fr_r.st != FS_SYNC) && (fr_r.st != FS_BYP);
		stat.oocmf = ctrl_r.crc_en && (fr_r.cmf != 2'h2);
		stat.oosmf = !ctrl_r.cas_dis && !fr_r.cas;
		stat.rai = fr_r.rai_d[0];
		stat.rmai = fr_r.rmai_d[0];
		stat.ais = fr_r.ais;
		stat.red = fr_r.red;
		stat.excrc = fr_r.excrc;
	end

	always_comb begin
		glob_nxt = glob_r;
		mode_nxt = mode_r;
		ctrl_nxt = ctrl_r;
		inten_nxt = inten_r;
		dat_nxt = dat_r;
		clr = '0;
		acc = wb_cyc_i && wb_stb_i && !ack_r;
		ack_nxt = acc;
		a = {wb_adr_i[7:2], 2'h0};
		m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		case (a)
			`E1RFP_GLOB_OFS: rd = {31'h0, glob_r};
			`E1RFP_MODE_OFS: rd = {28'h0, mode_r};
			`E1RFP_CTRL_OFS: rd = {21'h0, ctrl_r};
			`E1RFP_STAT_OFS: rd = {24'h0, stat};
			`E1RFP_EVT_OFS: rd = {26'h0, ev_r};
			`E1RFP_IEN_OFS: rd = {26'h0, inten_r};
			`E1RFP_OVH_OFS: rd = {22'h0, fr_r.xb, fr_r.nat, fr_r.si_nfas, fr_r.si_fas};
			`E1RFP_SACODE_OFS: rd = {12'h0, fr_r.sa_code};
			`E1RFP_CRCCNT_OFS: rd = {22'h0, fr_r.crc_rep};
			default: rd = 32'h0;
		endcase
		wv = (rd & ~m) | (wb_dat_i & m);
		if (acc && wb_we_i) begin
			case (a)
				`E1RFP_GLOB_OFS: glob_nxt = wv[0];
				`E1RFP_MODE_OFS: mode_nxt = wv[3:0];
				`E1RFP_CTRL_OFS: ctrl_nxt = wv[10:0];
				`E1RFP_EVT_OFS: clr = wb_dat_i[5:0] & m[5:0];
				`E1RFP_IEN_OFS: inten_nxt = wv[5:0];
				default: ;
			endcase
		end
		if (acc && !wb_we_i) begin
			dat_nxt = rd;
		end
		// a new event outranks a clear in the same cycle
		ev_nxt = (ev_r & ~clr) | ev_set | {(stat != stat_prev_r), 5'h00};
		int_nxt = |(ev_nxt & inten_nxt);
		mode_q_nxt.e1 = !glob_nxt;
		mode_q_nxt.rx_j1 = glob_nxt && mode_nxt[0] && mode_nxt[1];
		mode_q_nxt.tx_j1 = glob_nxt && mode_nxt[2] && mode_nxt[3];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			glob_r <= `E1RFP_GLOB_RST;
			mode_r <= `E1RFP_MODE_RST;
			ctrl_r <= `E1RFP_CTRL_RST;
			inten_r <= `E1RFP_IEN_RST;
			ev_r <= '0;
			// status as it reads right after reset, so no false change event
			stat_prev_r <= `E1RFP_STAT_RST;
			dat_r <= '0;
			ack_r <= 1'b0;
			int_r <= 1'b0;
			refp_r <= 1'b0;
			mode_q_r <= '0;
		end else begin
			glob_r <= glob_nxt;
			mode_r <= mode_nxt;
			ctrl_r <= ctrl_nxt;
			inten_r <= inten_nxt;
			ev_r <= ev_nxt;
			stat_prev_r <= stat;
			dat_r <= dat_nxt;
			ack_r <= ack_nxt;
			int_r <= int_nxt;
			refp_r <= ctrl_r.reframe;
			mode_q_r <= mode_q_nxt;
		end
	end

	// one instance per port and no shared state
	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign int_o = int_r;
	assign ts16_o = fr_r.ts16;
	assign ts16_en_o = fr_r.ts16_en;
	assign mode_o = mode_q_r;
endmodule

// file: tb/e1rfp_line_model.sv
// behavioural e1 line source feeding one framer port
`timescale 1ns/1ps
module e1rfp_line_model (
	input logic clk_i,
	input logic rst_i,
	input logic [1:0] pat_i,
	input logic rai_i,
	output logic rx_bit_o,
	output logic rx_en_o
);
	logic half_r;
	logic odd_r;
	logic [7:0] pos_r;
	logic [7:0] byte_w;
	always_comb begin
		byte_w = 8'h55; // filler keeps zeros in every frame unless pat_i is 2
		if (pos_r[7:3] == 5'h00) byte_w = odd_r ? {2'b11, rai_i, 5'h1f} : 8'h9b;
		if (pos_r[7:3] == 5'h10) byte_w = 8'ha5;
		if (pat_i == 2'h1 && pos_r[7:3] == 5'h00 && !odd_r) byte_w = 8'h64;
		if (pat_i == 2'h2) byte_w = 8'hff;
	end
	// strobe every other cycle; data toggles between strobes so stale bits never look valid
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			half_r <= 1'b0;
			odd_r <= 1'b0;
			pos_r <= 8'h00;
			rx_en_o <= 1'b0;
			rx_bit_o <= 1'b0;
		end else begin
			half_r <= !half_r;
			rx_en_o <= half_r;
			rx_bit_o <= half_r ? byte_w[3'h7 - pos_r[2:0]] : !rx_bit_o;
			if (half_r) begin
				pos_r <= pos_r + 8'h01;
				if (pos_r == 8'hff) odd_r <= !odd_r;
			end
		end
	end
endmodule

// file: tb/e1rfp_props.sv
// port checker for the e1 receive frame processor
`timescale 1ns/1ps
module e1rfp_props_chk
	import e1rfp_pkg::*;
#(
	parameter int AIS_FRAMES = 800,
	parameter int RED_FRAMES = 800,
	parameter int CMF_FRAMES = 3200,
	parameter int WIN_FRAMES = 64,
	parameter int SEC_FRAMES = 8000
) (
	input logic clk_i,
	input logic rst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	input logic rx_bit_en_i,
	input logic ts16_en_o,
	input e1rfp_pkg::e1rfp_mode_t mode_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged in the next cycle");
	chk_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	chk_dat_on_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o)
		else $error("read data changed outside an ack");
	chk_glob_mode: assert property (
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0]
		|-> ##2 mode_o.e1 == !$past(wb_dat_i[0], 2))
		else $error("line standard not applied");
	chk_j1_in_t1: assert property (mode_o.e1 |-> !mode_o.rx_j1 && !mode_o.tx_j1)
		else $error("japan mode flagged while in e1");
	chk_ts16_strobe: assert property (ts16_en_o |-> $past(rx_bit_en_i))
		else $error("ts16 strobe without a line bit");
	chk_ts16_e1_only: assert property (
		!mode_o.e1 && !$past(mode_o.e1) && !$past(mode_o.e1, 2) |-> !ts16_en_o)
		else $error("ts16 strobe outside e1 operation");
endmodule
bind e1rfp_frame_processor e1rfp_props_chk #(.AIS_FRAMES(AIS_FRAMES), .RED_FRAMES(RED_FRAMES),
	.CMF_FRAMES(CMF_FRAMES), .WIN_FRAMES(WIN_FRAMES), .SEC_FRAMES(SEC_FRAMES)) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .rx_bit_en_i(rx_bit_en_i), .ts16_en_o(ts16_en_o), .mode_o(mode_o));

// file: tb/tb_top.sv
// self-checking bench for the e1 receive frame processor
`timescale 1ns/1ps
module tb_top;
	import e1rfp_pkg::*;
	logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, rx_bit, rx_en, ts16, ts16_en, int_flag, rai;
	logic [7:0] wb_adr;
	logic [7:0] ts_sh, ts_byte;
	logic [3:0] wb_sel;
	logic [1:0] pat;
	logic [31:0] wb_wdat, wb_rdat, rdat;
	logic [3:0] mtab [4] = '{4'h3, 4'hc, 4'h5, 4'hf};
	e1rfp_mode_t mode;
	int errors, compares, cycles, ts_cnt, c0;
	e1rfp_frame_processor #(.AIS_FRAMES(8), .RED_FRAMES(8), .CMF_FRAMES(64), .WIN_FRAMES(40),
		.SEC_FRAMES(64)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rx_bit_i(rx_bit), .rx_bit_en_i(rx_en),
		.ts16_o(ts16), .ts16_en_o(ts16_en), .int_o(int_flag), .mode_o(mode));
	e1rfp_line_model line (.clk_i(clk_i), .rst_i(rst_i), .pat_i(pat), .rai_i(rai),
		.rx_bit_o(rx_bit), .rx_en_o(rx_en));
	always #12.5 clk_i = !clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (ts16_en) begin
			ts_sh <= {ts_sh[6:0], ts16};
			ts_cnt <= ts_cnt + 1;
			if (ts_cnt % 8 == 7) ts_byte <= {ts_sh[6:0], ts16};
		end
		if (cycles == 40000) begin
			errors = errors + 1;
			conclude();
		end
	end
	task conclude;
		if (errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// single classic cycle; the master never assumes the ack latency
	task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		rdat = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(rdat & m, e);
	endtask
	task frames(input int n);
		repeat (n * 512) @(posedge clk_i);
	endtask
	initial begin
		{clk_i, wb_cyc, wb_stb, wb_we, rai} = 5'h00;
		rst_i = 1'b1;
		wb_adr = 8'h00;
		wb_sel = 4'hf;
		wb_wdat = 32'h0;
		pat = 2'h0;
		errors = 0;
		compares = 0;
		cycles = 0;
		ts_cnt = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(8'h00, 32'hffffffff, 32'h1);
		rd_chk(8'h08, 32'hffffffff, 32'h0);
		rd_chk(8'h14, 32'hffffffff, 32'h0);
		bus(1'b1, 8'h3c, 32'hffffffff);
		rd_chk(8'h3c, 32'hffffffff, 32'h0);
		foreach (mtab[i]) begin
			bus(1'b1, 8'h04, {28'h0, mtab[i]});
			repeat (2) @(posedge clk_i);
			cmp(32'(mode), {30'h0, &mtab[i][1:0], &mtab[i][3:2]});
		end
		bus(1'b1, 8'h00, 32'h0);
		frames(5);
		cmp(32'(mode), 32'h4);
		rd_chk(8'h0c, 32'h1, 32'h0);
		c0 = ts_cnt;
		frames(1);
		cmp(32'(ts_cnt - c0), 32'h8);
		cmp({24'h0, ts_byte}, 32'ha5);
		rd_chk(8'h18, 32'h7f, 32'h7f);
		bus(1'b1, 8'h14, 32'h1);
		bus(1'b1, 8'h10, 32'h3f);
		pat <= 2'h1;
		// bad alignment words come every other frame; three in a row are needed
		frames(7);
		rd_chk(8'h0c, 32'h1, 32'h1);
		rd_chk(8'h10, 32'h1, 32'h1);
		cmp({31'h0, int_flag}, 32'h1);
		pat <= 2'h0;
		frames(5);
		bus(1'b1, 8'h10, 32'h3f);
		repeat (2) @(posedge clk_i);
		rd_chk(8'h0c, 32'h1, 32'h0);
		cmp({31'h0, int_flag}, 32'h0);
		rai <= 1'b1;
		frames(4);
		rd_chk(8'h0c, 32'h8, 32'h8);
		rd_chk(8'h1c, 32'hfffff, 32'hfffff);
		bus(1'b1, 8'h14, 32'h10);
		bus(1'b1, 8'h10, 32'h3f);
		frames(1);
		rd_chk(8'h10, 32'h10, 32'h10);
		cmp({31'h0, int_flag}, 32'h1);
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b1, 8'h08, 32'h4);
		repeat (4) @(posedge clk_i);
		rd_chk(8'h0c, 32'h1, 32'h1);
		bus(1'b1, 8'h08, 32'h20);
		frames(1);
		c0 = ts_cnt;
		frames(1);
		cmp(32'(ts_cnt - c0), 32'h0);
		bus(1'b1, 8'h08, 32'h0);
		pat <= 2'h2;
		frames(14);
		rd_chk(8'h0c, 32'h61, 32'h61);
		bus(1'b1, 8'h00, 32'h1);
		repeat (2) @(posedge clk_i);
		cmp(32'(mode), 32'h3);
		conclude();
	end
endmodule
